// ==== rtl/rec_pkg.sv ====
package rec_pkg;

  // Register indices and byte addresses; indices are not word aligned
  localparam logic [7:0]  REC_IDX_REG_CFG  = 8'h0b;  // Regulator config index
  localparam logic [7:0]  REC_IDX_SW_CFG   = 8'h0c;  // Load switch config index
  localparam logic [11:0] REC_ADDR_REG_CFG = 12'h02c; // Index times four
  localparam logic [11:0] REC_ADDR_SW_CFG  = 12'h030; // Index times four

  // Field positions
  localparam int REC_SEQ_LSB   = 5;  // Sequence code, bits 7..5
  localparam int REC_PDSC_BIT  = 4;  // Passive discharge
  localparam int REC_ADSC_BIT  = 3;  // Active discharge
  localparam int REC_EN_LSB    = 1;  // Enable select, bits 2..1
  localparam int REC_MODE_BIT  = 0;  // Regulator switch mode
  localparam int REC_SOFT_BIT  = 0;  // Switch gentle start

  // Reset values of writable fields
  localparam logic [1:0] REC_EN_RST   = 2'h0;
  localparam logic       REC_BIT_RST  = 1'b0;

  // Sequence codes
  localparam logic [2:0] REC_SEQ_OFF0  = 3'h0;
  localparam logic [2:0] REC_SEQ_ON    = 3'h1;
  localparam logic [2:0] REC_SEQ_P0    = 3'h2;
  localparam logic [2:0] REC_SEQ_P25   = 3'h3;
  localparam logic [2:0] REC_SEQ_P50   = 3'h4;
  localparam logic [2:0] REC_SEQ_OFF5  = 3'h5;
  localparam logic [2:0] REC_SEQ_PIN   = 3'h6;
  localparam logic [2:0] REC_SEQ_REG   = 3'h7;

  // Enable select codes
  localparam logic [1:0] REC_EN_OFF = 2'h0;
  localparam logic [1:0] REC_EN_ON  = 2'h1;
  localparam logic [1:0] REC_EN_PIN = 2'h2;

  // Gentle start window: 60 ms at 50 MHz
  localparam int          REC_CLK_HZ      = 50_000_000;
  localparam int          REC_SOFT_MS     = 60;
  localparam int          REC_SOFT_CYCLES = (REC_CLK_HZ / 1000) * REC_SOFT_MS;
  localparam int          REC_SOFT_W      = 22;

  // Boot progress from the sequencer
  typedef struct packed {
    logic at_0;    // Boot delay started
    logic at_25;   // 25 percent reached
    logic at_50;   // 50 percent reached
    logic at_100;  // Boot delay complete
  } rec_boot_t;

  // Resolved per-rail controls
  typedef struct packed {
    logic enable;       // Rail on
    logic passive_dsc;  // Passive discharge engaged
    logic active_dsc;   // Active pull-down engaged
  } rec_rail_t;

endpackage : rec_pkg

// ==== rtl/rec_resolve.sv ====
`timescale 1ns/1ps
`default_nettype none
// Resolves one rail's enable from its sequence code
module rec_resolve
  import rec_pkg::*;
(
  // Configuration
  input  wire logic [2:0] seq_code,
  input  wire logic [1:0] enable_select,
  // Conditions
  input  wire rec_boot_t  boot,
  input  wire logic       enable_pin,
  input  wire logic       control_pin,
  // Result
  output logic            rail_on
);

  // Register-controlled enable, valid only for code 111
  wire reg_on = (enable_select == REC_EN_ON) ||
                ((enable_select == REC_EN_PIN) && control_pin);

  // Sequence decode
  always_comb begin
    case (seq_code)
      REC_SEQ_OFF0: rail_on = 1'b0;
      REC_SEQ_ON:   rail_on = 1'b1;
      REC_SEQ_P0:   rail_on = boot.at_0;
      REC_SEQ_P25:  rail_on = boot.at_25;
      REC_SEQ_P50:  rail_on = boot.at_50;
      REC_SEQ_OFF5: rail_on = 1'b0;
      REC_SEQ_PIN:  rail_on = enable_pin;
      REC_SEQ_REG:  rail_on = boot.at_100 && reg_on;
      default:      rail_on = 1'b0;
    endcase
  end

endmodule : rec_resolve
`default_nettype wire

// ==== rtl/rec_rail_enable_config.sv ====
`timescale 1ns/1ps
`default_nettype none
module rec_rail_enable_config
  import rec_pkg::*;
#(
  parameter int SOFT_CYCLES = REC_SOFT_CYCLES  // Shorten for simulation
)(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // Sequence straps (static, fused)
  input  wire logic [2:0]  regulator_sequence_code,
  input  wire logic [2:0]  switch_sequence_code,
  // Boot sequencer progress (same clock)
  input  wire rec_boot_t   boot_progress,
  // Off or hard-reset entry pulse (same clock)
  input  wire logic        off_entry,
  // Pins
  input  wire logic        regulator_enable_pin,
  input  wire logic        load_switch_enable_pin,
  input  wire logic        multi_purpose_control_pin,
  // Analog controls
  output rec_rail_t        regulator_ctl,
  output logic             regulator_switch_mode,
  output rec_rail_t        switch_ctl,
  output logic             switch_current_limit
);

  // Register fields
  logic       reg_pdsc_q;       // Passive discharge bit
  logic       reg_adsc_q;       // Active discharge bit
  logic [1:0] reg_en_q;         // Regulator enable select
  logic       reg_mode_q;       // Regulator switch mode
  logic [1:0] sw_en_q;          // Switch enable select
  logic       sw_soft_q;        // Switch gentle start
  // Pin synchronisers
  logic [2:0] pin_s1_q;         // First stage, read only by second
  logic [2:0] pin_s2_q;         // Second stage
  // Straps registered every cycle after reset release
  logic [2:0] reg_seq_q;
  logic [2:0] sw_seq_q;
  // Rail state
  logic       reg_on_q;
  logic       sw_on_q;
  logic [REC_SOFT_W-1:0] soft_cnt_q;
  logic       off_q;            // Discharge on off entry held one cycle

  // Address decode
  wire hit_reg  = (paddr == REC_ADDR_REG_CFG);
  wire hit_sw   = (paddr == REC_ADDR_SW_CFG);
  wire access   = psel && penable;
  wire wr_reg   = access && pwrite && hit_reg;
  wire wr_sw    = access && pwrite && hit_sw;

  // Read views; sequence fields are read-only
  wire [7:0] reg_view = {reg_seq_q, reg_pdsc_q, reg_adsc_q, reg_en_q, reg_mode_q};
  wire [7:0] sw_view  = {sw_seq_q, 2'b00, sw_en_q, sw_soft_q};

  // Zero-wait slave; unmapped address errors
  assign pready  = 1'b1;
  assign pslverr = access && !(hit_reg || hit_sw);

  // Read data register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= hit_reg ? {24'h00_0000, reg_view} :
                hit_sw  ? {24'h00_0000, sw_view} : 32'h0000_0000;
    end
  end

  // Writable fields; sequence bits ignored on write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_pdsc_q <= REC_BIT_RST;
      reg_adsc_q <= REC_BIT_RST;
      reg_en_q   <= REC_EN_RST;
      reg_mode_q <= REC_BIT_RST;
      sw_en_q    <= REC_EN_RST;
      sw_soft_q  <= REC_BIT_RST;
    end else begin
      if (wr_reg) begin
        reg_pdsc_q <= pwdata[REC_PDSC_BIT];
        reg_adsc_q <= pwdata[REC_ADSC_BIT];
        reg_en_q   <= pwdata[REC_EN_LSB +: 2];
        reg_mode_q <= pwdata[REC_MODE_BIT];
      end
      if (wr_sw) begin
        sw_en_q   <= pwdata[REC_EN_LSB +: 2];
        sw_soft_q <= pwdata[REC_SOFT_BIT];
      end
    end
  end

  // Pin synchronisers and strap capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_q  <= 3'h0;
      pin_s2_q  <= 3'h0;
      reg_seq_q <= REC_SEQ_OFF0;
      sw_seq_q  <= REC_SEQ_OFF0;
    end else begin
      pin_s1_q  <= {multi_purpose_control_pin, load_switch_enable_pin, regulator_enable_pin};
      pin_s2_q  <= pin_s1_q;
      reg_seq_q <= regulator_sequence_code;
      sw_seq_q  <= switch_sequence_code;
    end
  end

  // Resolved enables
  logic reg_on_d;
  logic sw_on_d;

  rec_resolve u_reg_resolve (
    .seq_code      (reg_seq_q),
    .enable_select (reg_en_q),
    .boot          (boot_progress),
    .enable_pin    (pin_s2_q[0]),
    .control_pin   (pin_s2_q[2]),
    .rail_on       (reg_on_d)
  );

  rec_resolve u_sw_resolve (
    .seq_code      (sw_seq_q),
    .enable_select (sw_en_q),
    .boot          (boot_progress),
    .enable_pin    (pin_s2_q[1]),
    .control_pin   (pin_s2_q[2]),
    .rail_on       (sw_on_d)
  );

  // Gentle start window restarts at each switch rising enable
  wire sw_rise = sw_on_d && !sw_on_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_on_q   <= 1'b0;
      sw_on_q    <= 1'b0;
      off_q      <= 1'b0;
      soft_cnt_q <= '0;
    end else begin
      reg_on_q <= reg_on_d;
      sw_on_q  <= sw_on_d;
      off_q    <= off_entry;
      if (sw_rise && sw_soft_q) begin
        soft_cnt_q <= REC_SOFT_W'(SOFT_CYCLES);
      end else if (soft_cnt_q != '0) begin
        soft_cnt_q <= soft_cnt_q - 1'b1;
      end
    end
  end

  // Discharge bits act only when the regulator is off; off entry always discharges
  wire reg_dsc_base = off_q;
  assign regulator_ctl.enable      = reg_on_q;
  assign regulator_ctl.passive_dsc = reg_dsc_base || (reg_pdsc_q && !reg_on_q);
  assign regulator_ctl.active_dsc  = reg_dsc_base || (reg_adsc_q && !reg_on_q);
  // Load-switch mode: analog side drives FET fully from enable
  assign regulator_switch_mode     = reg_mode_q;
  assign switch_ctl.enable         = sw_on_q;
  assign switch_ctl.passive_dsc    = 1'b0;
  assign switch_ctl.active_dsc     = 1'b0;
  // Limit current while window counts and switch is on
  assign switch_current_limit      = sw_on_q && (soft_cnt_q != '0);

  // Sequence code 111 needs completed boot before register enable
  seq_reg_boot_a: assert property (@(posedge pclk) disable iff (!presetn)
    (reg_seq_q == REC_SEQ_REG && !boot_progress.at_100) |=> !reg_on_q)
    else $error("regulator enabled before boot completed");

  // Codes 000 and 101 keep the regulator off
  seq_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    (reg_seq_q == REC_SEQ_OFF0 || reg_seq_q == REC_SEQ_OFF5) |=> !reg_on_q)
    else $error("regulator on under disabled code");

  // Code 001 keeps the switch on
  sw_always_a: assert property (@(posedge pclk) disable iff (!presetn)
    (sw_seq_q == REC_SEQ_ON) |=> sw_on_q)
    else $error("switch off under always-on code");

  // Code 010 follows boot start
  seq_p0_a: assert property (@(posedge pclk) disable iff (!presetn)
    (reg_seq_q == REC_SEQ_P0) |=> (reg_on_q == $past(boot_progress.at_0)))
    else $error("regulator not tracking boot start");

  // Register enable 01 turns regulator on after boot under 111
  reg_en_a: assert property (@(posedge pclk) disable iff (!presetn)
    (reg_seq_q == REC_SEQ_REG && boot_progress.at_100 && reg_en_q == REC_EN_ON) |=> reg_on_q)
    else $error("register enable ignored");

  // Switch enable 00 under 111 keeps it off
  sw_en_a: assert property (@(posedge pclk) disable iff (!presetn)
    (sw_seq_q == REC_SEQ_REG && sw_en_q == REC_EN_OFF) |=> !sw_on_q)
    else $error("switch on while disabled");

  // Passive discharge with its bit set and the rail off, or one cycle after off entry
  pas_dsc_a: assert property (@(posedge pclk) disable iff (!presetn)
    ((reg_pdsc_q && !regulator_ctl.enable) || ($past(off_entry) && $past(presetn)))
      |-> regulator_ctl.passive_dsc)
    else $error("passive discharge missing");

  // Active discharge never while rail on outside off entry
  act_dsc_a: assert property (@(posedge pclk) disable iff (!presetn)
    (reg_on_q && !off_q) |-> !regulator_ctl.active_dsc)
    else $error("active discharge while enabled");

  // Gentle start sets the limit the cycle after enable and keeps it one more cycle while the switch stays on
  soft_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    (sw_rise && sw_soft_q && sw_on_d) |=>
      switch_current_limit ##1 (switch_current_limit || !switch_ctl.enable))
    else $error("current limit not applied");

  // Mode output follows its register bit
  mode_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_reg |=> (regulator_switch_mode == $past(pwdata[REC_MODE_BIT])))
    else $error("mode bit not applied");

endmodule : rec_rail_enable_config
`default_nettype wire

// ==== tb/rec_testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench
  import rec_pkg::*;
();
  // Bench-driven inputs
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [2:0]  rseq;
  logic [2:0]  sseq;
  rec_boot_t   boot;
  logic        off_entry;
  logic        rpin;
  logic        spin;
  logic        cpin;
  // Observed outputs
  logic        pready;
  logic        pslverr;
  logic [31:0] prdata;
  rec_rail_t   rctl;
  rec_rail_t   sctl;
  logic        rmode;
  logic        climit;
  // Bookkeeping
  logic [31:0] rd;
  logic        er;
  int          err_total;
  int          checks;
  logic [11:0] rows [17];  // Seq, select, boot, control pin, pin, expected enable

  // Short gentle-start window so the run stays brief
  rec_rail_enable_config #(.SOFT_CYCLES(16)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .regulator_sequence_code(rseq), .switch_sequence_code(sseq), .boot_progress(boot),
    .off_entry(off_entry), .regulator_enable_pin(rpin), .load_switch_enable_pin(spin),
    .multi_purpose_control_pin(cpin), .regulator_ctl(rctl), .regulator_switch_mode(rmode),
    .switch_ctl(sctl), .switch_current_limit(climit));

  // Free-running 50 MHz clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // Compare and count; unknowns never match
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Single place where the run ends
  task automatic conclude();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  // Watchdog sized well above the expected run length
  initial begin
    repeat (6000) @(posedge pclk);
    err_total++;
    conclude();
  end

  initial begin
    {psel, penable, pwrite, off_entry, rpin, spin, cpin} = 7'h00;
    paddr = 12'h000; pwdata = 32'h0000_0000;
    rseq = 3'h5; sseq = 3'h2; boot = 4'h0; presetn = 1'b0;
    err_total = 0; checks = 0;
    // Every sequence code and select code, boot 4 bits at_0 first
    rows = '{{3'h0,2'h1,4'hf,3'h0}, {3'h1,2'h0,4'h0,3'h1}, {3'h5,2'h1,4'hf,3'h0},
             {3'h2,2'h0,4'h8,3'h1}, {3'h2,2'h0,4'h0,3'h0}, {3'h3,2'h0,4'h8,3'h0},
             {3'h3,2'h0,4'hc,3'h1}, {3'h4,2'h0,4'hc,3'h0}, {3'h4,2'h0,4'he,3'h1},
             {3'h6,2'h0,4'h0,3'h3}, {3'h6,2'h1,4'hf,3'h4}, {3'h7,2'h1,4'hf,3'h1},
             {3'h7,2'h1,4'he,3'h0}, {3'h7,2'h2,4'hf,3'h5}, {3'h7,2'h2,4'hf,3'h0},
             {3'h7,2'h0,4'hf,3'h2}, {3'h7,2'h3,4'hf,3'h6}};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, read-only sequence fields, unmapped place
    apb(1'b0, REC_ADDR_REG_CFG, 32'h0000_0000);
    chk("reg_cfg_rst", rd, 32'h0000_00a0);
    apb(1'b1, REC_ADDR_REG_CFG, 32'hffff_ffff);
    apb(1'b0, REC_ADDR_REG_CFG, 32'h0000_0000);
    chk("reg_cfg_rw", rd, 32'h0000_00bf);
    apb(1'b1, REC_ADDR_SW_CFG, 32'hffff_ffff);
    apb(1'b0, REC_ADDR_SW_CFG, 32'h0000_0000);
    chk("sw_cfg_rw", rd, 32'h0000_0047);
    apb(1'b0, 12'h034, 32'h0000_0000);
    chk("unmapped_err", er, 32'h0000_0001);
    chk("unmapped_data", rd, 32'h0000_0000);
    // Table of enable resolutions, both rails alike
    for (int i = 0; i < 17; i++) begin
      @(posedge pclk);
      rseq <= rows[i][11:9];
      sseq <= rows[i][11:9];
      boot <= rows[i][6:3];
      cpin <= rows[i][2];
      rpin <= rows[i][1];
      spin <= rows[i][1];
      apb(1'b1, REC_ADDR_REG_CFG, {29'h0, rows[i][8:7], 1'h0});
      apb(1'b1, REC_ADDR_SW_CFG, {29'h0, rows[i][8:7], 1'h0});
      repeat (5) @(posedge pclk);
      chk("reg_en", rctl.enable, rows[i][0]);
      chk("sw_en", sctl.enable, rows[i][0]);
    end
    // Discharge while the rail is off, and mode bit
    rseq <= 3'h0;
    apb(1'b1, REC_ADDR_REG_CFG, 32'h0000_0019);
    repeat (3) @(posedge pclk);
    chk("pas_dsc_low", rctl.passive_dsc, 32'h0000_0001);
    chk("act_dsc_low", rctl.active_dsc, 32'h0000_0001);
    chk("mode_set", rmode, 32'h0000_0001);
    // Rail on: no discharge even with both bits set
    rseq <= 3'h1;
    repeat (3) @(posedge pclk);
    chk("pas_dsc_on", rctl.passive_dsc, 32'h0000_0000);
    chk("act_dsc_on", rctl.active_dsc, 32'h0000_0000);
    // Bits clear: only the off entry discharges
    rseq <= 3'h0;
    apb(1'b1, REC_ADDR_REG_CFG, 32'h0000_0000);
    repeat (3) @(posedge pclk);
    chk("pas_dsc_clr", rctl.passive_dsc, 32'h0000_0000);
    chk("mode_clr", rmode, 32'h0000_0000);
    off_entry <= 1'b1;
    @(posedge pclk);
    off_entry <= 1'b0;
    @(posedge pclk);
    chk("pas_dsc_entry", rctl.passive_dsc, 32'h0000_0001);
    chk("act_dsc_entry", rctl.active_dsc, 32'h0000_0001);
    chk("sw_dsc", {sctl.passive_dsc, sctl.active_dsc}, 32'h0000_0000);
    // Gentle start runs only a window after enable
    sseq <= 3'h7;
    boot <= 4'hf;
    apb(1'b1, REC_ADDR_SW_CFG, 32'h0000_0001);
    apb(1'b1, REC_ADDR_SW_CFG, 32'h0000_0003);
    repeat (3) @(posedge pclk);
    chk("limit_on", climit, 32'h0000_0001);
    repeat (20) @(posedge pclk);
    chk("limit_end", climit, 32'h0000_0000);
    chk("sw_still_on", sctl.enable, 32'h0000_0001);
    // Without the bit no limit on enable
    apb(1'b1, REC_ADDR_SW_CFG, 32'h0000_0000);
    repeat (3) @(posedge pclk);
    apb(1'b1, REC_ADDR_SW_CFG, 32'h0000_0002);
    repeat (3) @(posedge pclk);
    chk("limit_none", climit, 32'h0000_0000);
    // Reset in mid-run clears writable fields and the switch rail
    presetn <= 1'b0;
    @(posedge pclk);
    @(posedge pclk);
    chk("rst_sw_en", sctl.enable, 32'h0000_0000);
    chk("rst_mode", rmode, 32'h0000_0000);
    chk("rst_ready", pready, 32'h0000_0001);
    presetn <= 1'b1;
    apb(1'b0, REC_ADDR_SW_CFG, 32'h0000_0000);
    chk("rst_sw_cfg", rd, 32'h0000_00e0);
    conclude();
  end
endmodule : testbench
`default_nettype wire
